// File: rtl/tecpfd_pkg.sv
// constants for the timer/event counter with frequency-divider output
// assumes a single 100 MHz core clock and a plain strobe register port
package tecpfd_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] ADDR_CONTROL = 8'h0e; // timer_control
    localparam logic [7:0] ADDR_COUNT = 8'h0d; // count_value / preload
    localparam logic [7:0] ADDR_PIN_CFG = 8'h10; // shared pin data latch and direction
    localparam logic [7:0] ADDR_STATUS = 8'h11; // overflow flag, divider level
    // control field positions
    localparam int CTL_PSC_LSB = 0;
    localparam int CTL_EDGE_BIT = 3;
    localparam int CTL_RUN_BIT = 4;
    localparam int CTL_MODE_LSB = 6;
    // control reset value, bit 5 always zero
    localparam logic [7:0] CTL_RESET = 8'h08;
    localparam logic [7:0] CTL_WR_MASK = 8'hdf;
    // pin config bits: bit0 data latch, bit1 direction (1 = input), bit2 divider option
    localparam int PIN_LATCH_BIT = 0;
    localparam int PIN_DIR_BIT = 1;
    localparam int PIN_OPT_BIT = 2;
    localparam logic [2:0] PIN_RESET = 3'h3;
    // status bits: bit0 overflow flag (write one to clear), bit1 divider level
    localparam int STS_FLAG_BIT = 0;
    localparam int STS_DIV_BIT = 1;
    // mode codes
    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;
    localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage

// File: rtl/tecpfd_sync.sv
// three-stage synchroniser with edge detect for the external event pin
// assumes the pin is asynchronous to i_core_clk
module tecpfd_sync (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);
    logic [2:0] sync_ff; // stage 0 only feeds stage 1
    logic [2:0] nxt_sync;

    // shift in the pin
    always_comb begin
        nxt_sync = {sync_ff[1:0], i_pin};
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    // an edge counts while stage two holds the new level and stage three still the old one
    assign o_rise = sync_ff[1] & ~sync_ff[2];
    assign o_fall = ~sync_ff[1] & sync_ff[2];
endmodule

// File: rtl/tecpfd_prescale.sv
// free-running prescaler giving a one-cycle count enable at core / 2^sel
// assumes sel changes only by software writes; a change may shorten one period
module tecpfd_prescale #(
    parameter int SEL_W = 3
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [SEL_W-1:0] i_sel,
    output logic o_tick
);
    localparam int DIV_W = (1 << SEL_W) - 1;
    logic [DIV_W-1:0] div_ff; // synchronous binary divider
    logic [DIV_W-1:0] nxt_div;
    logic [DIV_W-1:0] mask;

    // advance the divider each cycle
    always_comb begin
        nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
        mask = DIV_W'((1 << i_sel) - 1);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // tick when the selected low bits are all ones; sel 0 ticks every cycle
    assign o_tick = ((div_ff & mask) == mask);
endmodule

// File: rtl/tecpfd_top.sv
// timer/event counter with preload, three modes and a divider output pin
// assumes software uses the plain strobe port; event pin is asynchronous
//
// Chosen here: the plain strobed port.
module tecpfd_top #(
    parameter int CNT_W = 8,
    parameter int PSC_W = 3
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_event_pin,
    input wire logic i_irq_ack,
    output logic o_overflow_flag,
    output logic o_wake,
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe_n,
    output logic o_pin_read
);
    // control register fields
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic [CNT_W-1:0] cnt_ff; // live count
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] pre_ff; // preload
    logic [CNT_W-1:0] nxt_pre;
    logic flag_ff; // overflow request
    logic nxt_flag;
    logic div_ff; // divider level
    logic nxt_div;
    logic pw_busy_ff; // pulse measurement in progress
    logic nxt_pw_busy;
    logic [2:0] pin_ff; // latch, direction, option
    logic [2:0] nxt_pin;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic wake_ff;
    logic nxt_wake;
    logic pout_ff;
    logic nxt_pout;
    logic poe_n_ff;
    logic nxt_poe_n;
    logic pread_ff;
    logic nxt_pread;
    logic [2:0] pin_sync_ff; // synchroniser for the shared pin readback
    logic [2:0] nxt_pin_sync;

    // decoded controls
    logic [1:0] mode;
    logic run;
    logic edge_sel;
    logic tick;
    logic ev_rise;
    logic ev_fall;
    logic adv; // advance the counter this cycle
    logic ovf; // counter passes its top value
    logic start_edge;
    logic stop_edge;
    logic rd_count;

    // address match helper, shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        hit = (a == want);
    endfunction

    assign mode = ctl_ff[tecpfd_pkg::CTL_MODE_LSB +: 2];
    assign run = ctl_ff[tecpfd_pkg::CTL_RUN_BIT];
    assign edge_sel = ctl_ff[tecpfd_pkg::CTL_EDGE_BIT];
    assign rd_count = i_rd & hit(i_addr, tecpfd_pkg::ADDR_COUNT);

    // prescaled internal count clock as a one-cycle enable
    tecpfd_prescale #(
        .SEL_W(PSC_W)
    ) u_psc (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_sel(ctl_ff[tecpfd_pkg::CTL_PSC_LSB +: PSC_W]),
        .o_tick(tick)
    );

    // event pin passes two flops before edges are taken
    tecpfd_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_pin(i_event_pin),
        .o_rise(ev_rise),
        .o_fall(ev_fall)
    );

    // pulse mode: with edge select one start on rise, stop on fall
    assign start_edge = edge_sel ? ev_rise : ev_fall;
    assign stop_edge = edge_sel ? ev_fall : ev_rise;

    // count source per mode; reads of the count freeze it for that cycle
    always_comb begin
        adv = 1'b0;
        case (mode)
            tecpfd_pkg::MODE_EVENT: begin
                adv = edge_sel ? ev_fall : ev_rise;
            end
            tecpfd_pkg::MODE_TIMER: begin
                adv = tick;
            end
            tecpfd_pkg::MODE_PULSE: begin
                adv = tick & pw_busy_ff;
            end
            default: begin
                adv = 1'b0;
            end
        endcase
        adv = adv & run & ~rd_count;
        ovf = adv & (cnt_ff == tecpfd_pkg::COUNT_MAX);
    end

    // counter, preload, control and pulse measurement state
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_pre = pre_ff;
        nxt_ctl = ctl_ff;
        nxt_pw_busy = pw_busy_ff;
        // counting: wrap reloads from preload in every mode
        if (ovf) begin
            nxt_cnt = pre_ff;
        end else if (adv) begin
            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // pulse measurement sequencing
        if (mode == tecpfd_pkg::MODE_PULSE && run) begin
            if (!pw_busy_ff && start_edge) begin
                nxt_pw_busy = 1'b1;
            end else if (pw_busy_ff && stop_edge) begin
                nxt_pw_busy = 1'b0;
                // result stays in the counter; run drops so later edges do nothing
                nxt_ctl[tecpfd_pkg::CTL_RUN_BIT] = 1'b0;
            end
        end else begin
            nxt_pw_busy = 1'b0;
        end
        // software write of control; only software clears run outside pulse mode
        if (i_wr && hit(i_addr, tecpfd_pkg::ADDR_CONTROL)) begin
            nxt_ctl = i_wdata & tecpfd_pkg::CTL_WR_MASK;
        end
        // write of count: stopped loads both, running loads preload only
        if (i_wr && hit(i_addr, tecpfd_pkg::ADDR_COUNT)) begin
            nxt_pre = i_wdata[CNT_W-1:0];
            if (!run) begin
                nxt_cnt = i_wdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ctl_ff <= tecpfd_pkg::CTL_RESET;
            cnt_ff <= '0; // undefined by design; zero for a clean start
            pre_ff <= '0;
            pw_busy_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            cnt_ff <= nxt_cnt;
            pre_ff <= nxt_pre;
            pw_busy_ff <= nxt_pw_busy;
        end
    end

    // sticky overflow flag, divider toggle and wake pulse
    always_comb begin
        nxt_flag = flag_ff;
        // clears first so a same-cycle overflow wins
        if (i_irq_ack) begin
            nxt_flag = 1'b0;
        end
        if (i_wr && hit(i_addr, tecpfd_pkg::ADDR_STATUS) && i_wdata[tecpfd_pkg::STS_FLAG_BIT]) begin
            nxt_flag = 1'b0;
        end
        if (ovf) begin
            nxt_flag = 1'b1;
        end
        nxt_div = ovf ? ~div_ff : div_ff;
        nxt_wake = ovf;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            flag_ff <= 1'b0;
            div_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            div_ff <= nxt_div;
            wake_ff <= nxt_wake;
        end
    end

    // shared pin: config register, drive and synchronised readback
    always_comb begin
        nxt_pin = pin_ff;
        if (i_wr && hit(i_addr, tecpfd_pkg::ADDR_PIN_CFG)) begin
            nxt_pin = i_wdata[2:0];
        end
        nxt_pin_sync = {pin_sync_ff[1:0], i_pin_in};
        // readback changes only once stages two and three agree
        nxt_pread = (pin_sync_ff[1] == pin_sync_ff[2]) ? pin_sync_ff[2] : pread_ff;
        // input direction keeps the plain input, no drive
        nxt_poe_n = pin_ff[tecpfd_pkg::PIN_DIR_BIT];
        if (pin_ff[tecpfd_pkg::PIN_OPT_BIT]) begin
            // latch one passes the divider, latch zero holds the pin low
            nxt_pout = pin_ff[tecpfd_pkg::PIN_LATCH_BIT] & div_ff;
        end else begin
            nxt_pout = pin_ff[tecpfd_pkg::PIN_LATCH_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pin_ff <= tecpfd_pkg::PIN_RESET;
            pin_sync_ff <= 3'h0;
            pread_ff <= 1'b0;
            poe_n_ff <= 1'b1;
            pout_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            pin_sync_ff <= nxt_pin_sync;
            pread_ff <= nxt_pread;
            poe_n_ff <= nxt_poe_n;
            pout_ff <= nxt_pout;
        end
    end

    // read mux, answer one cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_rd) begin
            if (hit(i_addr, tecpfd_pkg::ADDR_CONTROL)) begin
                nxt_rdata = ctl_ff & tecpfd_pkg::CTL_WR_MASK;
            end else if (hit(i_addr, tecpfd_pkg::ADDR_COUNT)) begin
                nxt_rdata = cnt_ff;
            end else if (hit(i_addr, tecpfd_pkg::ADDR_PIN_CFG)) begin
                nxt_rdata = {5'h00, pin_ff};
            end else if (hit(i_addr, tecpfd_pkg::ADDR_STATUS)) begin
                nxt_rdata = {5'h00, pread_ff, div_ff, flag_ff};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_overflow_flag = flag_ff;
    assign o_wake = wake_ff;
    assign o_pin_out = pout_ff;
    assign o_pin_oe_n = poe_n_ff;
    assign o_pin_read = pread_ff;
endmodule

// File: bench/tecpfd_chk.sv
// checker: register port, overflow flag, wake pulse and shared pin
// assumes one clock domain and the synchronous active-low reset
module tecpfd_chk (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_irq_ack,
    input wire logic i_pin_in,
    input wire logic [7:0] o_rdata,
    input wire logic o_overflow_flag,
    input wire logic o_wake,
    input wire logic o_pin_oe_n,
    input wire logic o_pin_read
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // any request that may drop the flag
    logic clr_req;
    assign clr_req = i_irq_ack | (i_wr & (i_addr == tecpfd_pkg::ADDR_STATUS) & i_wdata[0]);
    // pin config write, then a quiet cycle so the pin can settle
    sequence s_cfg_wr;
        i_wr && i_addr == tecpfd_pkg::ADDR_PIN_CFG;
    endsequence
    sequence s_cfg_quiet;
        !(i_wr && i_addr == tecpfd_pkg::ADDR_PIN_CFG);
    endsequence
    property p_rdata_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero");
    property p_ctl_bit5;
        i_rd && i_addr == tecpfd_pkg::ADDR_CONTROL |=> !o_rdata[5];
    endproperty
    a_ctl_bit5: assert property (p_ctl_bit5)
        else $error("control bit 5 reads one");
    property p_flag_rise;
        $rose(o_overflow_flag) |-> o_wake;
    endproperty
    a_flag_rise: assert property (p_flag_rise)
        else $error("flag set without wake");
    property p_wake_flag;
        o_wake |-> o_overflow_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake without flag");
    property p_flag_sticky;
        o_overflow_flag && !clr_req |=> o_overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped by itself");
    property p_cfg_oe;
        s_cfg_wr ##1 s_cfg_quiet |=> o_pin_oe_n == $past(i_wdata[1], 2);
    endproperty
    a_cfg_oe: assert property (p_cfg_oe)
        else $error("pin direction not applied");
    property p_pin_read;
        $stable(i_pin_in) [*6] |-> o_pin_read == i_pin_in;
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("pin level not seen");
    property p_status_rd;
        i_rd && i_addr == tecpfd_pkg::ADDR_STATUS |=>
            o_rdata[0] == $past(o_overflow_flag) && o_rdata[2] == $past(o_pin_read);
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status read mismatch");
endmodule
bind tecpfd_top tecpfd_chk tecpfd_chk_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_irq_ack(i_irq_ack),
    .i_pin_in(i_pin_in), .o_rdata(o_rdata), .o_overflow_flag(o_overflow_flag),
    .o_wake(o_wake), .o_pin_oe_n(o_pin_oe_n), .o_pin_read(o_pin_read));

// File: bench/tecpfd_evsrc.sv
// external event source on the counter input pin
// assumes its tasks are called from one bench process
module tecpfd_evsrc (
    input wire logic i_clk,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle low, always driven
    initial o_pin = 1'b0;
    // set a level just after an edge
    task automatic level(input logic lv);
        @(posedge i_clk);
        o_pin <= lv;
    endtask
    // n high pulses of w+1 cycles, at least w low cycles after each
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            level(1'b1);
            repeat (w) @(posedge i_clk);
            level(1'b0);
            repeat (w) @(posedge i_clk);
        end
    endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the timer/event counter
// assumes the checker is bound and the event source model is compiled
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] C = tecpfd_pkg::ADDR_CONTROL;
    localparam logic [7:0] N = tecpfd_pkg::ADDR_COUNT;
    localparam logic [7:0] P = tecpfd_pkg::ADDR_PIN_CFG;
    localparam logic [7:0] S = tecpfd_pkg::ADDR_STATUS;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0, pad = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, v2;
    logic flag, wake, pout, poe_n, pread, ev, pin;
    int fails = 0, n_tests = 0;
    always #5 clk = ~clk;
    // pad level: the block wins while it drives, else the bench pull
    assign pin = (poe_n === 1'b0) ? pout : pad;
    tecpfd_top tecpfd_top_i (.i_core_clk(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_event_pin(ev),
        .i_irq_ack(ack), .o_overflow_flag(flag), .o_wake(wake), .i_pin_in(pin),
        .o_pin_out(pout), .o_pin_oe_n(poe_n), .o_pin_read(pread));
    tecpfd_evsrc tecpfd_evsrc_i (.i_clk(clk), .o_pin(ev));
    // range compare; lo == hi for exact values
    task automatic chk(input string nm, input logic [7:0] lo, hi, got);
        n_tests++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, got);
            fails++;
        end
    endtask
    task automatic wrr(input logic [7:0] a, d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, lo, hi);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        chk(nm, lo, hi, v);
    endtask
    task automatic print_verdict;
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdc("ctl rst", C, 8'h08, 8'h08);
        rdc("unmapped", 8'h00, 8'h00, 8'h00);
        wrr(C, 8'h90);
        wrr(C, 8'h80);
        wrr(N, 8'h80);
        wrr(C, 8'h90);
        wrr(N, 8'h20);
        // back-to-back reads: the count must not move while read
        @(posedge clk);
        rd <= 1'b1;
        addr <= N;
        @(posedge clk);
        #1 v2 = rdata;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("held", v2, v2, rdata);
        chk("live", 8'h81, 8'h8f, v2);
        for (int i = 0; i < 300 && flag !== 1'b1; i++) @(posedge clk);
        rdc("run kept", C, 8'h90, 8'h90);
        wrr(C, 8'ha0);
        rdc("reload", N, 8'h20, 8'h28);
        rdc("bit5", C, 8'h80, 8'h80);
        rdc("status", S, 8'h03, 8'h03);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        #1 chk("ack", 8'h00, 8'h00, {7'h00, flag});
        // divider level is one after a single overflow
        wrr(P, 8'h05);
        repeat (2) @(posedge clk);
        chk("pfd on", 8'h01, 8'h01, {6'h00, poe_n, pout});
        wrr(P, 8'h04);
        repeat (2) @(posedge clk);
        chk("pfd off", 8'h00, 8'h00, {6'h00, poe_n, pout});
        pad <= 1'b1;
        wrr(P, 8'h07);
        repeat (6) @(posedge clk);
        rdc("pin in", S, 8'h06, 8'h06);
        // every prescale code; start and stop slack allows a few counts
        for (int s = 0; s < 8; s++) begin
            wrr(N, 8'h00);
            wrr(C, 8'h90 | s[7:0]);
            repeat (8 << s) @(posedge clk);
            wrr(C, 8'h80);
            rdc("prescale", N, 8'h07, 8'h0a);
        end
        // three pulses then a lone rise: only one edge polarity counts it
        for (int te = 1; te >= 0; te--) begin
            wrr(N, 8'h00);
            wrr(C, 8'h50 | 8'(te << 3));
            tecpfd_evsrc_i.pulses(3, 4);
            tecpfd_evsrc_i.level(1'b1);
            repeat (6) @(posedge clk);
            wrr(C, 8'h40);
            rdc("events", N, 8'h03 + 8'(1 - te), 8'h03 + 8'(1 - te));
            tecpfd_evsrc_i.level(1'b0);
            repeat (6) @(posedge clk);
        end
        wrr(N, 8'h55);
        wrr(C, 8'h10);
        repeat (20) @(posedge clk);
        rdc("mode off", N, 8'h55, 8'h55);
        // pulse width that overflows in mid-measure
        wrr(C, 8'hc8);
        wrr(N, 8'hf0);
        wrr(C, 8'hd8);
        tecpfd_evsrc_i.level(1'b1);
        repeat (20) @(posedge clk);
        tecpfd_evsrc_i.level(1'b0);
        repeat (8) @(posedge clk);
        rdc("width", N, 8'hf2, 8'hf6);
        v2 = v;
        chk("pw flag", 8'h01, 8'h01, {7'h00, flag});
        rdc("run off", C, 8'hc8, 8'hc8);
        tecpfd_evsrc_i.pulses(1, 10);
        repeat (6) @(posedge clk);
        rdc("held pw", N, v2, v2);
        wrr(S, 8'h01);
        #1 chk("w1c", 8'h00, 8'h00, {7'h00, flag});
        print_verdict();
    end
endmodule
